/* File: pwr_cond_defines.vh */
/*
 * Constants for the power-condition subcommand handler: subcommand codes,
 * parameter bit positions, timer limits, status and error bits, register map.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef PWR_COND_DEFINES_VH
`define PWR_COND_DEFINES_VH

// ----------------------------------------------------------------------------
// Subcommand codes in parameter bits 3..0
// ----------------------------------------------------------------------------
`define SUB_SET_TIMER      4'h2
`define SUB_SET_STATE      4'h3
`define SUB_ENABLE_FEAT    4'h4
`define SUB_DISABLE_FEAT   4'h5

// ----------------------------------------------------------------------------
// Parameter byte fields
// ----------------------------------------------------------------------------
`define PRM_UNITS_BIT      7
`define PRM_ENABLE_BIT     5
`define PRM_SAVE_BIT       4

// ----------------------------------------------------------------------------
// Timer limits in 100 ms units; one minute is 600 of them
// ----------------------------------------------------------------------------
`define TMR_MAX_100MS      24'h3BFFC4
`define TMR_MIN_100MS      24'h000000
`define TMR_MIN_PER_UNIT   24'h000258

// ----------------------------------------------------------------------------
// Completion status and error bits
// ----------------------------------------------------------------------------
`define STAT_ERR_BIT       0
`define STAT_RDY_BIT       6
`define STAT_BSY_BIT       7
`define ERR_ABORT_BIT      2
`define IDW120_FEAT_BIT    7

// ----------------------------------------------------------------------------
// Register map on the plain bus, 8-bit offsets
// ----------------------------------------------------------------------------
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_COND_SEL       8'h08
`define REG_CUR_TIMER      8'h0C
`define REG_SAV_TIMER      8'h10
`define REG_FLAGS          8'h14
`define REG_DEF_TIMER      8'h18
`define REG_CAPS           8'h1C
`define CTRL_RESET         8'h01
`define NUM_COND           4

`endif

/* File: power_condition_subcmd.v */
/*
 * Handler for the set-timer, set-state, enable and disable subcommands of the
 * extended power condition feature set. One command is taken per start pulse
 * from the task-file fields; completion answers one cycle later.
 * Assumes the command decoder has already recognised the set-features opcode
 * and that the feature enable survives resets through the persistent store:
 * the persistent bit is reloaded from persist_feat_i only when software sets
 * the load bit, so a core reset alone never changes it.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pwr_cond_defines.vh"

// Functional notes
// - Parameter bit 7 picks timer units: 0 is 100 ms, 1 is one minute.
// - Timer value is cylinder-high then cylinder-low, bits 15 to 0.
// - Code 2h sets timer; bit 5 enables, bit 4 saves.
// - Timer above maximum is clamped to maximum, below minimum raised to minimum.
// - Maximum is 3BFFC4h in 100 ms units, minimum is zero.
// - Set-timer aborts if feature off, condition fixed or unsupported, or unsavable save.
// - An aborted set-timer or set-state leaves all settings untouched.
// - Sector-count byte selects the power condition operated on.
// - Code 3h sets state; bit 5 enables, bit 4 saves, bits 7-6 reserved.
// - Set-state writes current enable, and copies it to saved when save is set.
// - Set-state aborts if condition fixed or unsupported, feature off, or unsavable save.
// - Code 4h enables the feature set; upper bits reserved.
// - Enable turns feature on, sets word 120 bit 7, disables advanced power management.
// - Enable loads current timer from default if saved is zero, else saved.
// - Enable starts a timer whose current value is non-zero and enabled.
// - Once enabled, the feature stays enabled across all resets.
// - Enable aborts when the feature set is not supported.
// - Code 5h disables the feature set; upper bits reserved.
// - Disable stops all timers, turns feature off, clears word 120 bit 7.
// - Once disabled, the feature stays disabled across all resets.
// - Disable aborts when feature already off or unsupported.
// - Set-timer stores value, enables if flag and non-zero, saves if allowed.
module power_condition_subcmd (
	input  wire        core_clk_i,
	input  wire        sys_rst_i,
	input  wire        cmd_start_i,
	input  wire [7:0]  prm_byte_i,
	input  wire [7:0]  cond_id_i,
	input  wire [7:0]  cyl_low_i,
	input  wire [7:0]  cyl_high_i,
	input  wire        persist_feat_i,
	input  wire [7:0]  reg_addr_i,
	input  wire [31:0] reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [31:0] reg_rdata_o,
	output reg         cmd_done_o,
	output reg  [7:0]  status_o,
	output reg  [7:0]  error_o,
	output reg         extended_power_feature_o,
	output reg         id_word120_bit7_o,
	output reg         advanced_power_mgmt_off_o,
	output reg  [3:0]  timer_run_o
);

	// ------------------------------------------------------------------------
	// Per-condition state
	// ------------------------------------------------------------------------
	reg [23:0] cur_timer [0:`NUM_COND-1];
	reg [23:0] sav_timer [0:`NUM_COND-1];
	reg [23:0] def_timer [0:`NUM_COND-1];
	reg [3:0]  cur_en;
	reg [3:0]  sav_en;
	reg [3:0]  supported;
	reg [3:0]  changeable;
	reg [3:0]  savable;
	reg        feat_supported;
	reg [1:0]  sel;

	// Units times value, then clamp. A full minute count reaches 26 bits, so
	// the product is formed at 32 bits and only cut after the clamp.
	function [23:0] scale_clamp;
		input        minute_units;
		input [15:0] value;
		reg   [31:0] raw;
		begin
			raw = minute_units ? ({16'h0000, value} * {8'h00, `TMR_MIN_PER_UNIT})
				: {16'h0000, value};
			if (raw > {8'h00, `TMR_MAX_100MS})
				scale_clamp = `TMR_MAX_100MS;
			else if (raw < {8'h00, `TMR_MIN_100MS})
				scale_clamp = `TMR_MIN_100MS;
			else
				scale_clamp = raw[23:0];
		end
	endfunction

	function cond_ok;
		input [7:0] id;
		input [3:0] sup;
		input [3:0] chg;
		begin
			cond_ok = (id[7:2] == 6'h00) && sup[id[1:0]] && chg[id[1:0]];
		end
	endfunction

	// ------------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------------
	wire [3:0]  sub_code = prm_byte_i[3:0];
	wire        p_enable = prm_byte_i[`PRM_ENABLE_BIT];
	wire        p_save   = prm_byte_i[`PRM_SAVE_BIT];
	wire [1:0]  cid      = cond_id_i[1:0];
	wire [15:0] tmr_in   = {cyl_high_i, cyl_low_i};
	wire [23:0] tmr_val  = scale_clamp(prm_byte_i[`PRM_UNITS_BIT], tmr_in);
	wire        cond_good = cond_ok(cond_id_i, supported, changeable);
	wire        save_bad = p_save && !savable[cid];
	wire        is_timer = (sub_code == `SUB_SET_TIMER);
	wire        is_state = (sub_code == `SUB_SET_STATE);
	wire        is_en    = (sub_code == `SUB_ENABLE_FEAT);
	wire        is_dis   = (sub_code == `SUB_DISABLE_FEAT);
	reg         abort_now;

	always @* begin
		abort_now = 1'b1;
		if (is_timer || is_state)
			abort_now = !extended_power_feature_o || !cond_good || save_bad;
		else if (is_en)
			abort_now = !feat_supported;
		else if (is_dis)
			abort_now = !feat_supported || !extended_power_feature_o;
	end

	// ------------------------------------------------------------------------
	// Command execution and register writes
	// ------------------------------------------------------------------------
	integer i;
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			cmd_done_o                <= 1'b0;
			status_o                  <= 8'h40;
			error_o                   <= 8'h00;
			cur_en                    <= 4'h0;
			sav_en                    <= 4'h0;
			supported                 <= 4'hF;
			changeable                <= 4'hF;
			savable                   <= 4'hF;
			feat_supported            <= 1'b1;
			sel                       <= 2'b00;
			timer_run_o               <= 4'h0;
			advanced_power_mgmt_off_o <= 1'b0;
			for (i = 0; i < `NUM_COND; i = i + 1) begin
				cur_timer[i] <= 24'h000000;
				sav_timer[i] <= 24'h000000;
				def_timer[i] <= 24'h000000;
			end
		end else begin
			cmd_done_o <= cmd_start_i;
			if (cmd_start_i) begin
				status_o <= 8'h40;
				error_o  <= 8'h00;
				if (abort_now) begin
					// Nothing is modified; only the completion shows the abort.
					status_o[`STAT_ERR_BIT] <= 1'b1;
					error_o[`ERR_ABORT_BIT] <= 1'b1;
				end else if (is_timer) begin
					cur_timer[cid] <= tmr_val;
					cur_en[cid]    <= p_enable && (tmr_val != 24'h000000);
					timer_run_o[cid] <= p_enable && (tmr_val != 24'h000000);
					if (p_save) begin
						sav_timer[cid] <= tmr_val;
						sav_en[cid]    <= p_enable && (tmr_val != 24'h000000);
					end
				end else if (is_state) begin
					cur_en[cid]      <= p_enable;
					timer_run_o[cid] <= p_enable && (cur_timer[cid] != 24'h000000);
					if (p_save)
						sav_en[cid] <= p_enable;
				end else if (is_en) begin
					advanced_power_mgmt_off_o <= 1'b1;
					for (i = 0; i < `NUM_COND; i = i + 1) begin
						if (sav_timer[i] == 24'h000000) begin
							cur_timer[i]   <= def_timer[i];
							timer_run_o[i] <= cur_en[i] && (def_timer[i] != 24'h000000);
						end else begin
							cur_timer[i]   <= sav_timer[i];
							timer_run_o[i] <= cur_en[i];
						end
					end
				end else begin
					timer_run_o <= 4'h0;
				end
			end else if (reg_wr_i) begin
				case (reg_addr_i)
				`REG_COND_SEL: sel <= reg_wdata_i[1:0];
				`REG_DEF_TIMER: def_timer[sel] <= reg_wdata_i[23:0];
				`REG_CAPS: begin
					supported      <= reg_wdata_i[3:0];
					changeable     <= reg_wdata_i[7:4];
					savable        <= reg_wdata_i[11:8];
					feat_supported <= reg_wdata_i[12];
				end
				default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Persistent feature enable
	// ------------------------------------------------------------------------
	// Held outside sys_rst_i so no reset changes it; software reloads it from
	// the nonvolatile copy through the control register load bit.
	initial extended_power_feature_o = 1'b0;
	always @(posedge core_clk_i) begin
		if (cmd_start_i && !abort_now && is_en)
			extended_power_feature_o <= 1'b1;
		else if (cmd_start_i && !abort_now && is_dis)
			extended_power_feature_o <= 1'b0;
		else if (reg_wr_i && reg_addr_i == `REG_CTRL && reg_wdata_i[0])
			extended_power_feature_o <= persist_feat_i;
	end

	always @* begin
		id_word120_bit7_o = extended_power_feature_o;
	end

	// ------------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------------
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
			`REG_STATUS: reg_rdata_o <= {16'h0000, error_o, status_o};
			`REG_COND_SEL: reg_rdata_o <= {30'h00000000, sel};
			`REG_CUR_TIMER: reg_rdata_o <= {8'h00, cur_timer[sel]};
			`REG_SAV_TIMER: reg_rdata_o <= {8'h00, sav_timer[sel]};
			`REG_FLAGS: reg_rdata_o <= {16'h0000, timer_run_o, sav_en, cur_en,
				1'b0, advanced_power_mgmt_off_o, feat_supported,
				extended_power_feature_o};
			`REG_DEF_TIMER: reg_rdata_o <= {8'h00, def_timer[sel]};
			`REG_CAPS: reg_rdata_o <= {19'h00000, feat_supported, savable,
				changeable, supported};
			default: reg_rdata_o <= 32'h00000000;
			endcase
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end

endmodule // power_condition_subcmd
`default_nettype wire

/* File: pcs_chk_properties.sv */
/* Port checker for the power-condition subcommand handler.
   Assumes it is bound to the top module: one clock, synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module pcs_chk (
	input wire logic       core_clk_i,
	input wire logic       sys_rst_i,
	input wire logic       cmd_start_i,
	input wire logic [7:0] prm_byte_i,
	input wire logic [7:0] cond_id_i,
	input wire logic       reg_wr_i,
	input wire logic       cmd_done_o,
	input wire logic [7:0] status_o,
	input wire logic [7:0] error_o,
	input wire logic       extended_power_feature_o,
	input wire logic       id_word120_bit7_o,
	input wire logic       advanced_power_mgmt_off_o,
	input wire logic [3:0] timer_run_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_done; cmd_start_i |=> cmd_done_o; endproperty
	a_done: assert property (p_done) else $error("no done");
	property p_nodone; !cmd_start_i |=> !cmd_done_o; endproperty
	a_nodone: assert property (p_nodone) else $error("stray done");
	property p_abt; cmd_done_o && status_o[0] |-> error_o == 8'h04 && status_o == 8'h41; endproperty
	a_abt: assert property (p_abt) else $error("abort status");
	property p_ok; cmd_done_o && !status_o[0] |-> error_o == 8'h00 && status_o == 8'h40; endproperty
	a_ok: assert property (p_ok) else $error("good status");
	property p_word; id_word120_bit7_o == extended_power_feature_o; endproperty
	a_word: assert property (p_word) else $error("word bit");
	property p_en; cmd_start_i && prm_byte_i[3:0] == 4'h4
		|=> status_o[0] || (extended_power_feature_o && advanced_power_mgmt_off_o); endproperty
	a_en: assert property (p_en) else $error("enable");
	property p_dis; cmd_start_i && prm_byte_i[3:0] == 4'h5
		|=> status_o[0] || (!extended_power_feature_o && timer_run_o == 4'h0); endproperty
	a_dis: assert property (p_dis) else $error("disable");
	property p_off; cmd_start_i && !extended_power_feature_o
		&& prm_byte_i[3:0] inside {4'h2, 4'h3, 4'h5} |=> status_o[0]; endproperty
	a_off: assert property (p_off) else $error("feature off");
	property p_id; cmd_start_i && prm_byte_i[3:1] == 3'h1 && cond_id_i >= 8'h04
		|=> status_o[0] && $stable(timer_run_o); endproperty
	a_id: assert property (p_id) else $error("bad id");
	property p_keep; !cmd_start_i && !reg_wr_i |=> $stable(extended_power_feature_o); endproperty
	a_keep: assert property (p_keep) else $error("feature moved");
endmodule // pcs_chk
`default_nettype wire

/* File: host_cmd_model.sv */
/* Host model that hands one subcommand at a time to the task-file inputs.
   Assumes the bench waits for the done pulse before the next call. */
`timescale 1ns/1ns
`default_nettype none
module host_cmd_model (
	input  wire logic       core_clk_i,
	output var  logic       start_o,
	output var  logic [7:0] prm_o,
	output var  logic [7:0] id_o,
	output var  logic [7:0] lo_o,
	output var  logic [7:0] hi_o
);
	initial begin
		start_o = 1'b0;
		{prm_o, id_o, hi_o, lo_o} = 32'h0;
	end
	task automatic issue(input logic [7:0] p, input logic [7:0] id, input logic [15:0] t);
		@(posedge core_clk_i);
		start_o <= 1'b1;
		prm_o <= p;
		id_o <= id;
		{hi_o, lo_o} <= t;
		@(posedge core_clk_i);
		start_o <= 1'b0;
		// Released fields are inverted so a late sample reads as garbage.
		prm_o <= ~p;
		id_o <= ~id;
		{hi_o, lo_o} <= ~t;
	endtask
endmodule // host_cmd_model
`default_nettype wire

/* File: power_condition_subcmd_tb.sv */
/* Self-checking bench for the power-condition subcommand handler.
   Assumes the host model and the bound checker are compiled beside it. */
`timescale 1ns/1ns
`default_nettype none
`include "pwr_cond_defines.vh"
module power_condition_subcmd_tb;
	logic        core_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        persist_feat_i = 1'b0;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic [31:0] d;
	wire         cmd_start_i, cmd_done_o, extended_power_feature_o;
	wire         id_word120_bit7_o, advanced_power_mgmt_off_o;
	wire [7:0]   prm_byte_i, cond_id_i, cyl_low_i, cyl_high_i, status_o, error_o;
	wire [31:0]  reg_rdata_o;
	wire [3:0]   timer_run_o;
	integer      num_errors = 0;
	integer      n_compared = 0;
	// Row: parameter byte, condition id, timer, expected status, expected feature.
	logic [47:0] cmd_rows [12] = '{48'h02_00_0010_41_00, 48'h05_00_0000_41_00,
		48'h04_00_0000_40_01, 48'h32_00_0010_40_01, 48'hA2_01_FFFF_40_01,
		48'h82_02_0002_40_01, 48'h12_03_0005_40_01, 48'h22_04_0001_41_01,
		48'h33_00_0000_40_01, 48'h33_05_0000_41_01, 48'h07_00_0000_41_01,
		48'h05_00_0000_40_00};
	logic [47:0] reg_rows [4] = '{{8'h00, `REG_CUR_TIMER, 32'h10},
		{8'h01, `REG_CUR_TIMER, 32'h3BFFC4}, {8'h02, `REG_CUR_TIMER, 32'h4B0},
		{8'h03, `REG_SAV_TIMER, 32'h5}};
	always #10 core_clk_i = ~core_clk_i;
	host_cmd_model m (.core_clk_i, .start_o(cmd_start_i), .prm_o(prm_byte_i),
		.id_o(cond_id_i), .lo_o(cyl_low_i), .hi_o(cyl_high_i));
	power_condition_subcmd dut (.core_clk_i, .sys_rst_i, .cmd_start_i, .prm_byte_i,
		.cond_id_i, .cyl_low_i, .cyl_high_i, .persist_feat_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .cmd_done_o, .status_o, .error_o,
		.extended_power_feature_o, .id_word120_bit7_o, .advanced_power_mgmt_off_o,
		.timer_run_o);
	task final_report;
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rst;
		@(posedge core_clk_i) sys_rst_i <= 1'b1;
		repeat (12) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i) reg_wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i) reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	task run_cmd(input logic [7:0] p, input logic [7:0] id, input logic [15:0] t,
		input logic [7:0] st);
		integer i;
		m.issue(p, id, t);
		#1 i = 0;
		while (cmd_done_o !== 1'b1 && i < 4) begin
			@(posedge core_clk_i) #1 i++;
		end
		if (i == 4) begin
			num_errors++;
			final_report();
		end
		chk("status", {24'h0, st}, {24'h0, status_o});
		chk("error", st[0] ? 32'h4 : 32'h0, {24'h0, error_o});
	endtask
	initial begin
		rst();
		foreach (cmd_rows[i]) begin
			run_cmd(cmd_rows[i][47:40], cmd_rows[i][39:32], cmd_rows[i][31:16], cmd_rows[i][15:8]);
			chk("feature", {31'h0, cmd_rows[i][0]}, {31'h0, extended_power_feature_o});
		end
		foreach (reg_rows[i]) begin
			wr(`REG_COND_SEL, {24'h0, reg_rows[i][47:40]});
			rd(reg_rows[i][39:32]);
			chk("timer", reg_rows[i][31:0], d);
		end
		wr(`REG_COND_SEL, 32'h1);
		wr(`REG_DEF_TIMER, 32'h77);
		run_cmd(8'h04, 8'h00, 16'h0, 8'h40);
		rd(`REG_CUR_TIMER);
		chk("loaded", 32'h77, d);
		chk("run", 32'h1, {31'h0, timer_run_o[1]});
		chk("apm off", 32'h1, {31'h0, advanced_power_mgmt_off_o});
		rst();
		chk("kept on", 32'h1, {31'h0, extended_power_feature_o});
		run_cmd(8'h05, 8'h00, 16'h0, 8'h40);
		rst();
		chk("kept off", 32'h0, {31'h0, extended_power_feature_o});
		wr(`REG_CAPS, 32'hFF);
		run_cmd(8'h04, 8'h00, 16'h0, 8'h41);
		wr(`REG_CAPS, 32'h10FF);
		run_cmd(8'h04, 8'h00, 16'h0, 8'h40);
		run_cmd(8'h02, 8'h00, 16'h33, 8'h40);
		run_cmd(8'h13, 8'h00, 16'h0, 8'h41);
		run_cmd(8'h12, 8'h00, 16'h9, 8'h41);
		wr(`REG_COND_SEL, 32'h0);
		rd(`REG_CUR_TIMER);
		chk("untouched", 32'h33, d);
		final_report();
	end
endmodule // power_condition_subcmd_tb
bind power_condition_subcmd pcs_chk u_chk (.core_clk_i, .sys_rst_i, .cmd_start_i, .prm_byte_i,
	.cond_id_i, .reg_wr_i, .cmd_done_o, .status_o, .error_o, .extended_power_feature_o,
	.id_word120_bit7_o, .advanced_power_mgmt_off_o, .timer_run_o);
`default_nettype wire
